/* hdl/ipr_prio_reg0.v */
// Purpose: priority control register 0 with AXI4-Lite access and source gating
// Assumes: single clock, requests from same clock domain
// Notes: 0x0 holds the fields, 0x4 reads gated request state
// Notes: writes to 0x4 answer OKAY and change nothing; other offsets answer SLVERR
// Notes: requests and levels trail the register by one clock
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "ipr_consts.vh"
module ipr_prio_reg0 (
    input wire clk_i,
    input wire arst_n_i,
    input wire [`IPR_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`IPR_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] src_enable_i,
    input wire [3:0] src_flag_i,
    output wire [3:0] src_req_o,
    output wire [11:0] src_level_o,
    output wire [15:0] irq_priority_ctrl_0_o
);
    reg [15:0] irq_priority_ctrl_0_r;
    reg aw_got_r;
    reg w_got_r;
    reg [`IPR_ADDR_W-1:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire [15:0] wmask;
    wire do_write;
    reg [15:0] irq_priority_ctrl_0_nxt;
    reg [31:0] rd_data_nxt;
    reg [1:0] rd_resp_nxt;
    reg [1:0] wr_resp_nxt;
    wire [2:0] wr_sel;
    wire [2:0] rd_sel;
    wire [31:0] stat_word;
    wire [11:0] prio_fields;
    wire [2:0] timer_one_prio;
    wire [2:0] out_compare_one_prio;
    wire [2:0] in_capture_one_prio;
    wire [2:0] ext_irq_zero_prio;

    // One-hot register select codes
    localparam [2:0] SEL_NONE = 3'h1;
    localparam [2:0] SEL_PRIO = 3'h2;
    localparam [2:0] SEL_STAT = 3'h4;

    // Field extraction, fields ordered ext0, capture1, compare1, timer1
    function [2:0] fld;
        input [15:0] reg_v;
        input integer idx;
        begin
            fld = reg_v[idx*4 +: 3];
        end
    endfunction

    // Register select, shared by the write and read channels
    function [2:0] reg_sel;
        input [`IPR_ADDR_W-1:0] addr_v;
        begin
            if ({addr_v[`IPR_ADDR_W-1:2], 2'h0} == `IPR_PRIO_CTRL_0_OFS) begin
                reg_sel = SEL_PRIO;
            end else if ({addr_v[`IPR_ADDR_W-1:2], 2'h0} == `IPR_SRC_STAT_OFS) begin
                reg_sel = SEL_STAT;
            end else begin
                reg_sel = SEL_NONE;
            end
        end
    endfunction

    // Named views of the four priority fields
    // Code 000 turns a source off; 001..111 are levels 1..7
    assign ext_irq_zero_prio = fld(irq_priority_ctrl_0_r, 0);
    assign in_capture_one_prio = fld(irq_priority_ctrl_0_r, 1);
    assign out_compare_one_prio = fld(irq_priority_ctrl_0_r, 2);
    assign timer_one_prio = fld(irq_priority_ctrl_0_r, 3);
    assign prio_fields = {timer_one_prio, out_compare_one_prio,
                          in_capture_one_prio, ext_irq_zero_prio};
    assign wr_sel = reg_sel(aw_addr_r);
    assign rd_sel = reg_sel(s_axi_araddr);

    // Gated request state as seen by software
    assign stat_word = {28'h0000000, src_req_o};

    // Address and data taken in either order, one write at a time
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}} & `IPR_WR_MASK;

    // only field bits take write data
    always @* begin
        irq_priority_ctrl_0_nxt = irq_priority_ctrl_0_r;
        // Only a completed write on the priority offset changes the word
        if (do_write && (wr_sel == SEL_PRIO)) begin
            irq_priority_ctrl_0_nxt = (irq_priority_ctrl_0_r & ~wmask) |
                                      (w_data_r[15:0] & wmask);
        end
    end

    // Write response: status word ignores writes, other offsets refused
    always @* begin
        case (wr_sel)
            SEL_PRIO: wr_resp_nxt = `IPR_RESP_OKAY;
            SEL_STAT: wr_resp_nxt = `IPR_RESP_OKAY;
            default: wr_resp_nxt = `IPR_RESP_SLVERR;
        endcase
    end

    // Reset word: every field at code 100, spare bits clear
    localparam [15:0] PRIO_RST_WORD = {1'b0, `IPR_FIELD_RST, 1'b0, `IPR_FIELD_RST,
                                       1'b0, `IPR_FIELD_RST, 1'b0, `IPR_FIELD_RST};

    // Priority register; spare bits never loaded so they read zero
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_priority_ctrl_0_r <= PRIO_RST_WORD;
        end else begin
            irq_priority_ctrl_0_r <= irq_priority_ctrl_0_nxt;
        end
    end

    // Write channel capture and write response
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= {`IPR_ADDR_W{1'b0}};
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IPR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_resp_nxt;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel, one read in flight: address refused while rvalid stands
    assign s_axi_arready = !s_axi_rvalid;

    // Read data and response chosen from the select code
    always @* begin
        rd_data_nxt = 32'h0000_0000;
        rd_resp_nxt = `IPR_RESP_OKAY;
        case (rd_sel)
            SEL_PRIO: begin
                rd_data_nxt = {16'h0000, irq_priority_ctrl_0_r & `IPR_WR_MASK};
            end
            SEL_STAT: begin
                rd_data_nxt = stat_word;
            end
            default: begin
                rd_resp_nxt = `IPR_RESP_SLVERR;
            end
        endcase
    end

    // Answer one cycle after the address; data held while rvalid stands
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `IPR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data_nxt;
            s_axi_rresp <= rd_resp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Register value straight from the flops
    assign irq_priority_ctrl_0_o = irq_priority_ctrl_0_r;

    // One gate per source
    // Requests and levels are registered, so they follow a field write
    // by one clock; the arbiter outside sees both change together
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
            ipr_src_gate u_gate (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .prio_i(prio_fields[gi*3 +: 3]),
                .enable_i(src_enable_i[gi]),
                .flag_i(src_flag_i[gi]),
                .req_o(src_req_o[gi]),
                .level_o(src_level_o[gi*3 +: 3])
            );
        end
    endgenerate
endmodule // ipr_prio_reg0

/* shared/ipr_consts.vh */
// Purpose: constants for the interrupt priority control register 0 block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: What this block does is listed below
// What this block does
// - Field code 111 means priority level 7, the highest level.
// - Code 001 is level 1, lowest enabled; codes between map in order.
// - Code 000 disables the source: no request whatever enable and flag say.
// - Output compare 1 priority lives in bits 10..8, read/write; bit 11 unused.
`ifndef IPR_CONSTS_VH
`define IPR_CONSTS_VH
`define IPR_ADDR_W 4
`define IPR_PRIO_CTRL_0_OFS 4'h0
`define IPR_SRC_STAT_OFS 4'h4
`define IPR_TMR1_LSB 12
`define IPR_OC1_LSB 8
`define IPR_IC1_LSB 4
`define IPR_INT0_LSB 0
`define IPR_FIELD_RST 3'h4
`define IPR_WR_MASK 16'h7777
`define IPR_PRIO_OFF 3'h0
`define IPR_PRIO_MAX 3'h7
`define IPR_RESP_OKAY 2'h0
`define IPR_RESP_SLVERR 2'h2
`endif

/* hdl/ipr_src_gate.v */
// Purpose: turns one 3-bit priority field into a gated request and level
// Assumes: enable and flag come from logic on the same clock
// Notes: level output is registered
`include "ipr_consts.vh"
module ipr_src_gate (
    input wire clk_i,
    input wire arst_n_i,
    input wire [2:0] prio_i,
    input wire enable_i,
    input wire flag_i,
    output reg req_o,
    output reg [2:0] level_o
);
    // Zero disables, 1..7 pass straight through as the level
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_o <= 1'b0;
            level_o <= 3'h0;
        end else begin
            req_o <= enable_i & flag_i & (prio_i != `IPR_PRIO_OFF);
            level_o <= prio_i;
        end
    end
endmodule // ipr_src_gate

/* sim/ipr_prio_reg0_props.sv */
// Purpose: assertions on priority register 0 outputs
// Assumes: one clock, async active-low reset
// Notes: bound onto the top module
module ipr_prio_reg0_props (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] src_enable_i,
    input wire logic [3:0] src_flag_i,
    input wire logic [3:0] src_req_o,
    input wire logic [11:0] src_level_o,
    input wire logic [15:0] irq_priority_ctrl_0_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [15:0] c = irq_priority_ctrl_0_o;
    wire [3:0] nz = {|c[14:12], |c[10:8], |c[6:4], |c[2:0]};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Levels, requests and spare bits against the fields
    a_level_code: assert property ($past(arst_n_i) |->
        src_level_o == $past({c[14:12], c[10:8], c[6:4], c[2:0]}))
        else $error("level differs from field code");
    a_top_level: assert property (c[14:12] == 3'h7 |=> src_level_o[11:9] == 3'h7)
        else $error("code 111 not level 7");
    a_req_gate: assert property (src_req_o == $past(src_enable_i & src_flag_i & nz))
        else $error("request gating wrong");
    a_spare_zero: assert property ({c[15], c[11], c[7], c[3]} == 4'h0)
        else $error("spare bit set");
    a_reset_val: assert property ($rose(arst_n_i) |-> c == 16'h4444)
        else $error("reset value wrong");
    // Main scenarios reached
    c_req: cover property (src_req_o != 4'h0);
    c_top: cover property (src_level_o[11:9] == 3'h7);
    c_off: cover property (c == 16'h0000);
endmodule // ipr_prio_reg0_props
bind ipr_prio_reg0 ipr_prio_reg0_props u_props (.*);

/* sim/ipr_prio_reg0_tb_top.sv */
// Purpose: register-level bench for priority register 0
// Assumes: AXI4-Lite master task, 125 MHz clock
// Notes: no random stimulus
`include "ipr_consts.vh"
module ipr_prio_reg0_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, arst_n_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0, src_req_o;
    logic [3:0] src_enable_i = 0, src_flag_i = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [11:0] src_level_o;
    logic [15:0] irq_priority_ctrl_0_o;
    int mismatches = 0, checks = 0;
    ipr_prio_reg0 dut (.*);
    initial forever #4 clk_i = ~clk_i;
    // Compare and count
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One bus access, write when w is set; bounded wait
    task acc(input logic w, input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        if (w) begin
            {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, s};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end else begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        for (n = 0; n < 40; n++) begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            rsp = w ? s_axi_bresp : s_axi_rresp;
            d = s_axi_rdata;
            if (w ? s_axi_bvalid : s_axi_rvalid) break;
        end
        {s_axi_bready, s_axi_rready} <= 2'h0;
        mismatches += (n == 40);
        if (n == 40) complete_run;
        @(posedge clk_i);
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        {arst_n_i, src_enable_i, src_flag_i} <= 9'h1FF;
        @(posedge clk_i);
        acc(1'h0, `IPR_PRIO_CTRL_0_OFS, 32'h0, 4'h0);
        chk(d, 32'h4444);
        chk(src_level_o, 12'h924);
        acc(1'h1, `IPR_PRIO_CTRL_0_OFS, 32'hFFFF, 4'hF);
        acc(1'h0, `IPR_PRIO_CTRL_0_OFS, 32'h0, 4'h0);
        chk(d, 32'h7777);
        chk(src_level_o, 12'hFFF);
        acc(1'h1, `IPR_PRIO_CTRL_0_OFS, 32'h3210, 4'hF);
        chk(rsp, `IPR_RESP_OKAY);
        acc(1'h0, `IPR_SRC_STAT_OFS, 32'h0, 4'h0);
        chk(d, 32'hE);
        chk(src_level_o, 12'h688);
        src_enable_i <= 4'hD;
        @(posedge clk_i);
        acc(1'h0, `IPR_SRC_STAT_OFS, 32'h0, 4'h0);
        chk(d, 32'hC);
        acc(1'h1, `IPR_PRIO_CTRL_0_OFS, 32'hFFFF, 4'h1);
        acc(1'h0, `IPR_PRIO_CTRL_0_OFS, 32'h0, 4'h0);
        chk(d, 32'h3277);
        acc(1'h1, `IPR_SRC_STAT_OFS, 32'hFFFF, 4'hF);
        chk(rsp, `IPR_RESP_OKAY);
        chk(irq_priority_ctrl_0_o, 16'h3277);
        acc(1'h1, 4'h8, 32'hFFFF, 4'hF);
        chk(rsp, `IPR_RESP_SLVERR);
        acc(1'h0, 4'h8, 32'h0, 4'h0);
        chk(rsp, `IPR_RESP_SLVERR);
        chk(d, 32'h0);
        complete_run;
    end
endmodule // ipr_prio_reg0_tb_top
